// file: hw/rsi_pkg.sv
// Shared constants for the receive interrupt status block: register map,
// status bit positions, reset values and receiver framing figures.
// Assumes a 32-bit AXI4-Lite bus with byte addresses four times the index.
`default_nettype none

package rsi_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] IDX_CTRL = 8'h06;
    localparam logic [7:0] IDX_STATUS = 8'h08;
    localparam logic [7:0] IDX_DATA_B = 8'h0b;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = IDX_CTRL << 2;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = IDX_STATUS << 2;
    localparam logic [ADDR_W-1:0] ADDR_DATA_B = IDX_DATA_B << 2;

    // ------------------------------------------------------------------
    // Status bits
    // ------------------------------------------------------------------
    localparam int BIT_VALID_B = 7;
    localparam int BIT_FLOW_B = 6;
    localparam int BIT_EOF_B = 5;
    localparam int BIT_FULL_B = 4;
    localparam int BIT_VALID_A = 3;

    // ------------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam int EOF_LEN_W = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Receiver framing
    // ------------------------------------------------------------------
    localparam int BYTE_BITS = 8;
    localparam int BIT_CNT_W = 4;
    localparam logic [BIT_CNT_W-1:0] BYTE_LAST = 4'h8;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_W = BYTE_BITS + 1;

    typedef enum logic {RX_IDLE, RX_ACTIVE} rsi_rx_e;

endpackage

`default_nettype wire

// file: hw/rsi_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two and both sides share mclk.
`default_nettype none

module rsi_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wrPtr_ff;
    logic [PW-1:0] rdPtr_ff;
    logic [CW-1:0] count_ff;
    logic push;
    logic pop;

    assign inReady = count_ff != CW'(DEPTH);
    assign outValid = count_ff != '0;
    assign outData = mem_ff[rdPtr_ff];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    for (genvar g = 0; g < DEPTH; g++) begin : gSlot
        always_ff @(posedge mclk) begin
            if (push && wrPtr_ff == PW'(g)) begin
                mem_ff[g] <= inData;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pointers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            wrPtr_ff <= push ? wrPtr_ff + 1'b1 : wrPtr_ff;
            rdPtr_ff <= pop ? rdPtr_ff + 1'b1 : rdPtr_ff;
            count_ff <= count_ff + CW'(push) - CW'(pop);
        end
    end

endmodule

`default_nettype wire

// file: hw/rsi_irq_status.sv
// Receive interrupt status logic: channel B framing, data holding register,
// flow, end-of-frame, full and valid flags, and the AXI4-Lite slave.
// Assumes receiver strobes and the bus are synchronous to mclk.
// Function
// (R1) A byte from the channel B receiver that cannot be loaded because unread data fills the path sets the flow error flag.
// (R2) A host read of the channel B data register while it is empty sets the flow error flag.
// (R3) The flow error flag reads at status bit 6.
// (R4) A host read of the status register clears the flow error and end-of-frame flags.
// (R5) The end-of-frame flag reads at status bit 5.
// (R6) Once reception has begun, end of frame is raised when more invalid bit times pass than the configured length.
// (R7) The register-full flag reads at status bit 4.
// (R8) Full is set whenever the data register is loaded, by a whole byte or a partial one at end of frame.
// (R9) Status bit 3 reads 1 only when every bit of the last channel A byte was valid.
// (R10) The valid indicators update on each load and drive no interrupt request.
// (R11) Status bit 7 shows that every bit of the channel B data register is valid.
// (R12) An event in the same cycle as the clearing read keeps its flag set.
`default_nettype none

module rsi_irq_status #(
    parameter int FIFO_DEPTH = rsi_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [rsi_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [rsi_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rsi_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [rsi_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rxbBitStb,
    input wire logic rxbBitOk,
    input wire logic rxbBitVal,
    output logic rxbFifoReady,
    input wire logic rxaLoad,
    input wire logic rxaAllValid
);
    localparam int AW = rsi_pkg::ADDR_W;
    localparam int BB = rsi_pkg::BYTE_BITS;
    localparam int CW = rsi_pkg::BIT_CNT_W;
    localparam int EW = rsi_pkg::EOF_LEN_W;

    function automatic logic addrHit(input logic [AW-1:0] addr, input logic [AW-1:0] target);
        return addr[AW-1:2] == target[AW-1:2];
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [AW-1:0] awAddr_ff;
    logic awHeld_ff;
    logic [rsi_pkg::DATA_W-1:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic wHeld_ff;
    logic bValid_ff;
    logic [1:0] bResp_ff;
    logic rValid_ff;
    logic [rsi_pkg::DATA_W-1:0] rData_ff;
    logic [1:0] rResp_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] dataB_ff;
    logic flowB_ff;
    logic eofB_ff;
    logic fullB_ff;
    logic validB_ff;
    logic validA_ff;
    rsi_pkg::rsi_rx_e rxState_ff;
    rsi_pkg::rsi_rx_e nxt_rxState;
    logic [BB-1:0] shift_ff;
    logic [BB-1:0] nxt_shift;
    logic [CW-1:0] bitCnt_ff;
    logic [CW-1:0] nxt_bitCnt;
    logic allOk_ff;
    logic nxt_allOk;
    logic [EW-1:0] gapCnt_ff;
    logic [EW-1:0] nxt_gapCnt;
    logic pushValid;
    logic [rsi_pkg::FIFO_W-1:0] pushData;
    logic eofEvt;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire doWrite = awHeld_ff && wHeld_ff;
    wire wrCtrl = doWrite && addrHit(awAddr_ff, rsi_pkg::ADDR_CTRL) && wStrb_ff[0];
    wire wrMapped = addrHit(awAddr_ff, rsi_pkg::ADDR_CTRL)
        || addrHit(awAddr_ff, rsi_pkg::ADDR_STATUS)
        || addrHit(awAddr_ff, rsi_pkg::ADDR_DATA_B);
    wire rdTake = s_axi_arvalid && s_axi_arready;
    wire hitStatus = addrHit(s_axi_araddr, rsi_pkg::ADDR_STATUS);
    wire hitDataB = addrHit(s_axi_araddr, rsi_pkg::ADDR_DATA_B);
    wire hitCtrl = addrHit(s_axi_araddr, rsi_pkg::ADDR_CTRL);
    wire rdStatus = rdTake && hitStatus;
    wire rdDataB = rdTake && hitDataB;
    wire [EW-1:0] eofLen = ctrl_ff[EW-1:0];

    // Channel A flow, end-of-frame and full flags live elsewhere; read zero
    wire [7:0] statusWord = {validB_ff, flowB_ff, eofB_ff, fullB_ff, validA_ff,
        3'h0}; // see (R3) (R5) (R7) (R9) (R11)
    wire [7:0] rdByte = hitStatus ? statusWord : hitDataB ? dataB_ff : hitCtrl ? ctrl_ff : 8'h00;
    wire rdMapped = hitStatus || hitDataB || hitCtrl;

    assign s_axi_awready = !awHeld_ff && !bValid_ff;
    assign s_axi_wready = !wHeld_ff && !bValid_ff;
    assign s_axi_bvalid = bValid_ff;
    assign s_axi_bresp = bResp_ff;
    assign s_axi_arready = !rValid_ff;
    assign s_axi_rvalid = rValid_ff;
    assign s_axi_rdata = rData_ff;
    assign s_axi_rresp = rResp_ff;

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            bValid_ff <= 1'b0;
            awAddr_ff <= '0;
            wData_ff <= '0;
            wStrb_ff <= '0;
            bResp_ff <= rsi_pkg::RESP_OKAY;
            ctrl_ff <= rsi_pkg::CTRL_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_ff <= s_axi_awaddr;
                awHeld_ff <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
                wHeld_ff <= 1'b1;
            end
            if (doWrite) begin
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
                bValid_ff <= 1'b1;
                bResp_ff <= wrMapped ? rsi_pkg::RESP_OKAY : rsi_pkg::RESP_SLVERR;
            end else if (bValid_ff && s_axi_bready) begin
                bValid_ff <= 1'b0;
            end
            if (wrCtrl) begin
                ctrl_ff <= wData_ff[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    // Read side effects happen at address acceptance, so a stalled rready
    // never repeats a clear
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rValid_ff <= 1'b0;
            rData_ff <= '0;
            rResp_ff <= rsi_pkg::RESP_OKAY;
        end else if (rdTake) begin
            rValid_ff <= 1'b1;
            rData_ff <= {24'h000000, rdByte};
            rResp_ff <= rdMapped ? rsi_pkg::RESP_OKAY : rsi_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rValid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Channel B bit framing
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rxState = rxState_ff;
        nxt_shift = shift_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_allOk = allOk_ff;
        nxt_gapCnt = gapCnt_ff;
        pushValid = 1'b0;
        pushData = {1'b0, shift_ff};
        eofEvt = 1'b0;
        if (rxbBitStb) begin
            unique case (rxState_ff)
                rsi_pkg::RX_IDLE: begin
                    if (rxbBitOk) begin
                        nxt_rxState = rsi_pkg::RX_ACTIVE;
                        nxt_shift = {{(BB-1){1'b0}}, rxbBitVal};
                        nxt_bitCnt = CW'(1);
                        nxt_allOk = 1'b1;
                        nxt_gapCnt = '0;
                    end
                end
                rsi_pkg::RX_ACTIVE: begin
                    if (!rxbBitOk && gapCnt_ff == eofLen) begin
                        eofEvt = 1'b1; // see (R6)
                        nxt_rxState = rsi_pkg::RX_IDLE;
                        pushValid = bitCnt_ff != '0; // see (R8)
                        pushData = {1'b0, shift_ff};
                        nxt_bitCnt = '0;
                    end else begin
                        nxt_shift = {shift_ff[BB-2:0], rxbBitVal};
                        nxt_allOk = allOk_ff && rxbBitOk;
                        nxt_gapCnt = rxbBitOk ? '0 : gapCnt_ff + 1'b1;
                        nxt_bitCnt = bitCnt_ff + 1'b1;
                        if (nxt_bitCnt == rsi_pkg::BYTE_LAST) begin
                            pushValid = 1'b1; // see (R8)
                            pushData = {nxt_allOk, nxt_shift};
                            nxt_bitCnt = '0;
                            nxt_shift = '0;
                            nxt_allOk = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rxState_ff <= rsi_pkg::RX_IDLE;
            shift_ff <= '0;
            bitCnt_ff <= '0;
            allOk_ff <= 1'b0;
            gapCnt_ff <= '0;
        end else begin
            rxState_ff <= nxt_rxState;
            shift_ff <= nxt_shift;
            bitCnt_ff <= nxt_bitCnt;
            allOk_ff <= nxt_allOk;
            gapCnt_ff <= nxt_gapCnt;
        end
    end

    // ------------------------------------------------------------------
    // Byte path into the data register
    // ------------------------------------------------------------------
    // The FIFO absorbs bursts while software is slow; only when it is full
    // is a byte dropped
    logic fifoOutValid;
    logic [rsi_pkg::FIFO_W-1:0] fifoOut;
    wire loadB = fifoOutValid && !fullB_ff;

    rsi_fifo #(
        .WIDTH(rsi_pkg::FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) uFifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .inValid(pushValid),
        .inData(pushData),
        .inReady(rxbFifoReady),
        .outValid(fifoOutValid),
        .outReady(!fullB_ff),
        .outData(fifoOut)
    );

    wire overflowB = pushValid && !rxbFifoReady; // see (R1)
    wire underflowB = rdDataB && !fullB_ff; // see (R2)

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    wire nxt_flowB = overflowB || underflowB || (flowB_ff && !rdStatus); // see (R4) (R12)
    wire nxt_eofB = eofEvt || (eofB_ff && !rdStatus); // see (R4) (R12)
    wire nxt_fullB = loadB || (fullB_ff && !rdDataB); // see (R8)
    // Valid flags feed only the status word, never a request line
    wire nxt_validB = loadB ? fifoOut[BB] : validB_ff; // see (R10) (R11)
    wire nxt_validA = rxaLoad ? rxaAllValid : validA_ff; // see (R9) (R10)

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            {validB_ff, flowB_ff, eofB_ff, fullB_ff, validA_ff} <= rsi_pkg::STATUS_RST[7:3];
            dataB_ff <= rsi_pkg::DATA_RST;
        end else begin
            flowB_ff <= nxt_flowB;
            eofB_ff <= nxt_eofB;
            fullB_ff <= nxt_fullB;
            validB_ff <= nxt_validB;
            validA_ff <= nxt_validA;
            dataB_ff <= loadB ? fifoOut[BB-1:0] : dataB_ff;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    overflow_flags_a: assert property ( // see (R1)
        pushValid && !rxbFifoReady |=> flowB_ff && ($stable(dataB_ff) || $past(loadB)))
        else $error("overflow did not set flow flag");
    underflow_flags_a: assert property ( // see (R2)
        rdTake && hitDataB && !fullB_ff |=> flowB_ff && s_axi_rvalid)
        else $error("underflow did not set flow flag");
    status_bits_a: assert property ( // see (R3) (R5) (R7) (R9) (R11)
        rdStatus |=> s_axi_rdata[rsi_pkg::BIT_VALID_B] == $past(validB_ff)
            && s_axi_rdata[rsi_pkg::BIT_FLOW_B] == $past(flowB_ff)
            && s_axi_rdata[rsi_pkg::BIT_EOF_B] == $past(eofB_ff)
            && s_axi_rdata[rsi_pkg::BIT_FULL_B] == $past(fullB_ff)
            && s_axi_rdata[rsi_pkg::BIT_VALID_A] == $past(validA_ff) && s_axi_rdata[2:0] == 3'h0)
        else $error("status word does not match flags");
    read_clear_a: assert property ( // see (R4)
        rdStatus && !overflowB && !underflowB && !eofEvt |=> !flowB_ff && !eofB_ff)
        else $error("status read did not clear flags");
    clear_collide_a: assert property ( // see (R12)
        rdStatus && overflowB |=> flowB_ff)
        else $error("flow event lost against status read");
    eof_collide_a: assert property ( // see (R12)
        rdStatus && eofEvt |=> eofB_ff)
        else $error("end of frame lost against status read");
    eof_timing_a: assert property ( // see (R6)
        rxState_ff == rsi_pkg::RX_ACTIVE && rxbBitStb && !rxbBitOk && gapCnt_ff == eofLen
        |=> eofB_ff && rxState_ff == rsi_pkg::RX_IDLE)
        else $error("end of frame missed");
    eof_cause_a: assert property ( // see (R6)
        $rose(eofB_ff) |-> $past(rxState_ff) == rsi_pkg::RX_ACTIVE && $past(rxbBitStb)
            && !$past(rxbBitOk))
        else $error("end of frame without gap");
    full_load_a: assert property ( // see (R8) (R10)
        loadB |=> fullB_ff && validB_ff == $past(fifoOut[BB]) && dataB_ff == $past(
            fifoOut[BB-1:0]))
        else $error("data load did not set full and valid");
    valid_a_a: assert property ( // see (R10)
        rxaLoad |=> validA_ff == $past(rxaAllValid))
        else $error("channel A valid not updated");

endmodule

`default_nettype wire

// file: sim/rsi_rx_src.sv
// Channel B receiver front end model: one strobe per bit time, bench driven.
// Assumes its tasks are called from a single bench process clocked by mclk.
`default_nettype none

module rsi_rx_src (
    input wire logic mclk,
    output logic bitStb,
    output logic bitOk,
    output logic bitVal
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        bitStb = 1'h0;
        bitOk = 1'h0;
        bitVal = 1'h0;
    end

    // ------------------------------------------------------------------
    // Bit times
    // ------------------------------------------------------------------
    // Value line flips after each strobe so a stale level never reads as data
    task automatic send_bit(input logic ok, input logic v);
        @(posedge mclk);
        bitStb <= 1'h1;
        bitOk <= ok;
        bitVal <= v;
        @(posedge mclk);
        bitStb <= 1'h0;
        bitVal <= ~v;
    endtask

    // Most significant bit goes out first
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            send_bit(1'h1, b[i]);
        end
    endtask
endmodule

`default_nettype wire

// file: sim/test_rx_serial_deserializer_irq_status.sv
// Self-checking bench for the receive interrupt status block.
// Assumes the AXI4-Lite slave and the channel B bit source share mclk.
`default_nettype none

module test_rx_serial_deserializer_irq_status;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk = 1'h0;
    logic sysRst = 1'h1;
    logic [7:0] awAddr = 8'h00;
    logic [7:0] arAddr = 8'h00;
    logic [31:0] wData = 32'h0;
    logic [3:0] wStrb = 4'h0;
    logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
    logic rxaLoad = 1'h0, rxaAllValid = 1'h0, vA = 1'h0;
    logic awReady, wReady, bValid, arReady, rValid, fifoRdy, stb, ok, val;
    logic [1:0] bResp, rResp;
    logic [31:0] rData;
    int n_mismatch = 0;
    int tests_run = 0;

    always #25 mclk = ~mclk;

    rsi_rx_src src_u (.mclk(mclk), .bitStb(stb), .bitOk(ok), .bitVal(val));

    rsi_irq_status #(.FIFO_DEPTH(4)) dut_u (
        .mclk(mclk), .sys_rst(sysRst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .rxbBitStb(stb), .rxbBitOk(ok),
        .rxbBitVal(val), .rxbFifoReady(fifoRdy), .rxaLoad(rxaLoad),
        .rxaAllValid(rxaAllValid)
    );

    // ------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------
    task automatic results();
        $display("Counts: %0d compares, %0d mismatches", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stall();
        n_mismatch++;
        $display("Error at %0t: bus handshake timed out", $time);
        results();
    endtask

    // ------------------------------------------------------------------
    // AXI4-Lite master
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'h0;
        w = 1'h0;
        r = 2'h0;
        @(posedge mclk);
        awAddr <= a;
        awValid <= 1'h1;
        wData <= d;
        wStrb <= s;
        wValid <= 1'h1;
        bReady <= 1'h1;
        for (int n = 0; n < 64; n++) begin
            @(posedge mclk);
            if (!aw && awReady === 1'h1) begin
                aw = 1'h1;
                awValid <= 1'h0;
            end
            if (!w && wReady === 1'h1) begin
                w = 1'h1;
                wValid <= 1'h0;
            end
            if (bValid === 1'h1) begin
                r = bResp;
                bReady <= 1'h0;
                return;
            end
        end
        stall();
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar;
        ar = 1'h0;
        d = 32'h0;
        r = 2'h0;
        @(posedge mclk);
        arAddr <= a;
        arValid <= 1'h1;
        rReady <= 1'h1;
        for (int n = 0; n < 64; n++) begin
            @(posedge mclk);
            if (!ar && arReady === 1'h1) begin
                ar = 1'h1;
                arValid <= 1'h0;
            end
            if (rValid === 1'h1) begin
                d = rData;
                r = rResp;
                rReady <= 1'h0;
                return;
            end
        end
        stall();
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(d, e);
        check({30'h0, r}, {30'h0, er});
    endtask

    // Status word expected from the flags; channel A valid comes from vA
    function automatic logic [31:0] stat(input logic vb, input logic fl, input logic eo,
                                         input logic fu);
        logic [31:0] s;
        s = 32'h0;
        s[rsi_pkg::BIT_VALID_B] = vb;
        s[rsi_pkg::BIT_FLOW_B] = fl;
        s[rsi_pkg::BIT_EOF_B] = eo;
        s[rsi_pkg::BIT_FULL_B] = fu;
        s[rsi_pkg::BIT_VALID_A] = vA;
        return s;
    endfunction

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] b;
        logic [7:0] p;
        int len;
        logic [7:0] q[$];
        d = $urandom(40606);
        repeat (12) @(posedge mclk);
        sysRst <= 1'h0;
        rdchk(rsi_pkg::ADDR_STATUS, {24'h0, rsi_pkg::STATUS_RST}, rsi_pkg::RESP_OKAY);
        rdchk(rsi_pkg::ADDR_CTRL, {24'h0, rsi_pkg::CTRL_RST}, rsi_pkg::RESP_OKAY);
        rdchk(8'h3c, 32'h0, rsi_pkg::RESP_SLVERR);
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk);
            rxaLoad <= 1'h1;
            rxaAllValid <= i[0];
            @(posedge mclk);
            rxaLoad <= 1'h0;
            rxaAllValid <= ~i[0];
            vA = i[0];
            rdchk(rsi_pkg::ADDR_STATUS, stat(0, 0, 0, 0), rsi_pkg::RESP_OKAY);
        end
        $display("test reset and channel A valid done");
        len = $urandom_range(4, 0);
        d = $urandom;
        d[3:0] = len[3:0];
        wr(rsi_pkg::ADDR_CTRL, d, 4'h1, r);
        rdchk(rsi_pkg::ADDR_CTRL, {24'h0, d[7:0]}, rsi_pkg::RESP_OKAY);
        wr(rsi_pkg::ADDR_CTRL, ~d, 4'h0, r);
        rdchk(rsi_pkg::ADDR_CTRL, {24'h0, d[7:0]}, rsi_pkg::RESP_OKAY);
        wr(rsi_pkg::ADDR_STATUS, 32'hff, 4'hf, r);
        check({30'h0, r}, {30'h0, rsi_pkg::RESP_OKAY});
        rdchk(rsi_pkg::ADDR_STATUS, stat(0, 0, 0, 0), rsi_pkg::RESP_OKAY);
        wr(8'h3c, d, 4'hf, r);
        check({30'h0, r}, {30'h0, rsi_pkg::RESP_SLVERR});
        $display("test register access done");
        b = $urandom;
        src_u.send_byte(b);
        repeat (4) @(posedge mclk);
        rdchk(rsi_pkg::ADDR_STATUS, stat(1, 0, 0, 1), rsi_pkg::RESP_OKAY);
        rdchk(rsi_pkg::ADDR_DATA_B, {24'h0, b}, rsi_pkg::RESP_OKAY);
        rdchk(rsi_pkg::ADDR_STATUS, stat(1, 0, 0, 0), rsi_pkg::RESP_OKAY);
        // A second read of an emptied data register is an underflow
        rdchk(rsi_pkg::ADDR_DATA_B, {24'h0, b}, rsi_pkg::RESP_OKAY);
        rdchk(rsi_pkg::ADDR_STATUS, stat(1, 1, 0, 0), rsi_pkg::RESP_OKAY);
        rdchk(rsi_pkg::ADDR_STATUS, stat(1, 0, 0, 0), rsi_pkg::RESP_OKAY);
        $display("test byte and underflow done");
        p = 8'h00;
        for (int i = 0; i < 3 + len; i++) begin
            b[0] = 1'($urandom);
            src_u.send_bit(i < 3, b[0]);
            p = {p[6:0], b[0]};
        end
        // The end-of-frame bit lands on the edge of a clearing status read
        fork
            rdchk(rsi_pkg::ADDR_STATUS, stat(1, 0, 0, 0), rsi_pkg::RESP_OKAY);
            src_u.send_bit(1'h0, 1'($urandom));
        join
        repeat (4) @(posedge mclk);
        rdchk(rsi_pkg::ADDR_STATUS, stat(0, 0, 1, 1), rsi_pkg::RESP_OKAY);
        rdchk(rsi_pkg::ADDR_DATA_B, {24'h0, p}, rsi_pkg::RESP_OKAY);
        rdchk(rsi_pkg::ADDR_STATUS, stat(0, 0, 0, 0), rsi_pkg::RESP_OKAY);
        $display("test end of frame done");
        // Host stalls: one byte in the register, four queued, the sixth is lost
        for (int i = 0; i < 6; i++) begin
            b = $urandom;
            q.push_back(b);
            // The lost byte lands on the edge of a clearing status read
            fork
                src_u.send_byte(b);
                if (i == 5) begin
                    repeat (14) @(posedge mclk);
                    rdchk(rsi_pkg::ADDR_STATUS, stat(1, 0, 0, 1),
                          rsi_pkg::RESP_OKAY);
                end
            join
            if (i == 4) begin
                repeat (2) @(posedge mclk);
                check({31'h0, fifoRdy}, 32'h0);
            end
        end
        repeat (4) @(posedge mclk);
        rdchk(rsi_pkg::ADDR_STATUS, stat(1, 1, 0, 1), rsi_pkg::RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            rdchk(rsi_pkg::ADDR_DATA_B, {24'h0, q[i]}, rsi_pkg::RESP_OKAY);
            repeat (3) @(posedge mclk);
        end
        check({31'h0, fifoRdy}, 32'h1);
        rdchk(rsi_pkg::ADDR_STATUS, stat(1, 0, 0, 0), rsi_pkg::RESP_OKAY);
        $display("test overflow and drain done");
        results();
    end
endmodule

`default_nettype wire
